// *** rtcc_params.svh ***
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

`define RTCC_ADDR_W 12
`define RTCC_IDX_CAL_SEC 8'h40
`define RTCC_IDX_CAL_MIN 8'h41
`define RTCC_IDX_CAL_HOUR 8'h42
`define RTCC_IDX_CAL_DAY 8'h43
`define RTCC_IDX_CAL_MON 8'h44
`define RTCC_IDX_CAL_YEAR 8'h45
`define RTCC_IDX_WAKE_SEC 8'h46
`define RTCC_IDX_WAKE_MIN 8'h47
`define RTCC_IDX_WAKE_HOUR 8'h48
`define RTCC_IDX_WAKE_DAY 8'h49
`define RTCC_IDX_WAKE_MON 8'h4a
`define RTCC_IDX_WAKE_YEAR 8'h4b
`define RTCC_IDX_EPOCH0 8'h4c
`define RTCC_IDX_EPOCH1 8'h4d
`define RTCC_IDX_EPOCH2 8'h4e
`define RTCC_IDX_EPOCH3 8'h4f
`define RTCC_BIT_READ_DONE 7
`define RTCC_BIT_MONITOR 6
`define RTCC_BIT_TICK_WAKE 5
`define RTCC_BIT_TICK_TYPE 4
`define RTCC_BIT_TICK_ON 7
`define RTCC_BIT_ALARM_ON 6
`define RTCC_SEC_MAX 6'h3b
`define RTCC_HOUR_MAX 5'h17
`define RTCC_MON_MAX 4'hc
`define RTCC_DAY_MIN 5'h01
`define RTCC_MON_MIN 4'h1
`define RTCC_CAUSE_NONE 2'h0
`define RTCC_SEC_NS 1000000000
`define RTCC_CLK_NS 10
`define RTCC_SEC_CYCLES (`RTCC_SEC_NS / `RTCC_CLK_NS)
`endif

// *** rtcc_pkg.sv ***
`default_nettype none
package rtcc_pkg;
	typedef logic [31:0] rtcc_word_t;
	typedef struct packed {
		logic [5:0] sec;
		logic [5:0] min;
		logic [4:0] hour;
		logic [4:0] day;
		logic [3:0] mon;
		logic [5:0] year;
	} rtcc_cal_t;
	typedef struct packed {
		logic [5:0] min;
		logic [4:0] hour;
		logic [4:0] day;
		logic [3:0] mon;
		logic tick_wake;
		logic tick_type;
		logic [5:0] year;
		logic tick_on;
		logic alarm_on;
	} rtcc_wake_t;
endpackage : rtcc_pkg
`default_nettype wire

// *** rtcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_params.svh"
module rtcc_top #(
	parameter int unsigned SEC_CYCLES = `RTCC_SEC_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RTCC_ADDR_W-1:0] paddr,
	input wire rtcc_pkg::rtcc_word_t pwdata,
	output rtcc_pkg::rtcc_word_t prdata,
	output logic pready,
	output logic pslverr,
	output logic wake_out
);
	import rtcc_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	rtcc_cal_t run;
	rtcc_cal_t stage;
	rtcc_cal_t next_run;
	rtcc_wake_t wake_stage;
	rtcc_wake_t wake_act;
	logic [5:0] wake_sec;
	logic [31:0] epoch_run;
	logic [31:0] epoch_snap;
	logic [31:0] prescale;
	logic sec_tick;
	logic power_ok;
	logic read_done;
	logic [1:0] cause;
	logic match;
	logic match_q;
	logic alarm_evt;
	logic tick_evt;
	logic acc;
	logic done;
	logic hit;
	logic [7:0] idx;
	logic wr;
	logic rd_acc;
	logic [7:0] rdata8;
	logic [7:0] wbyte;

	// ----------------------------------------
	// Month length
	// ----------------------------------------
	function automatic logic [4:0] month_days(input logic [3:0] mon, input logic [5:0] year);
		logic [4:0] d;
		d = 5'h1f;
		if (mon == 4'h2) begin
			// Years 2000 to 2063: every multiple of four is a leap year
			d = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
		end else if (mon == 4'h4 || mon == 4'h6 || mon == 4'h9 || mon == 4'hb) begin
			d = 5'h1e;
		end
		return d;
	endfunction : month_days

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// One wait state: prdata and pready both come from flip-flops
	assign acc = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign idx = paddr[9:2];
	assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && (idx[7:4] == 4'h4);
	assign wr = done & pwrite & hit;
	assign rd_acc = acc & ~pwrite & hit;
	assign wbyte = pwdata[7:0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
		end else begin
			pready <= acc;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= acc & ~hit;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0;
		end else if (acc) begin
			prdata <= {24'h0, rdata8};
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rdata8 = 8'h0;
		if (hit) begin
			unique case (idx)
				// Seconds read returns the value the snapshot captures
				`RTCC_IDX_CAL_SEC: rdata8 = {read_done, 1'b0, run.sec};
				`RTCC_IDX_CAL_MIN: rdata8 = {2'h0, stage.min};
				`RTCC_IDX_CAL_HOUR: rdata8 = {3'h0, stage.hour};
				`RTCC_IDX_CAL_DAY: rdata8 = {3'h0, stage.day};
				`RTCC_IDX_CAL_MON: rdata8 = {4'h0, stage.mon};
				`RTCC_IDX_CAL_YEAR: rdata8 = {1'b0, power_ok, stage.year};
				`RTCC_IDX_WAKE_SEC: rdata8 = {cause, wake_sec};
				`RTCC_IDX_WAKE_MIN: rdata8 = {2'h0, wake_stage.min};
				`RTCC_IDX_WAKE_HOUR: rdata8 = {3'h0, wake_stage.hour};
				`RTCC_IDX_WAKE_DAY: rdata8 = {3'h0, wake_stage.day};
				`RTCC_IDX_WAKE_MON: begin
					rdata8 = {2'h0, wake_stage.tick_wake, wake_stage.tick_type, wake_stage.mon};
				end
				`RTCC_IDX_WAKE_YEAR: begin
					rdata8 = {wake_stage.tick_on, wake_stage.alarm_on, wake_stage.year};
				end
				`RTCC_IDX_EPOCH0: rdata8 = epoch_run[7:0];
				`RTCC_IDX_EPOCH1: rdata8 = epoch_snap[15:8];
				`RTCC_IDX_EPOCH2: rdata8 = epoch_snap[23:16];
				`RTCC_IDX_EPOCH3: rdata8 = epoch_snap[31:24];
				default: rdata8 = 8'h0;
			endcase
		end
	end

	// ----------------------------------------
	// Seconds prescaler
	// ----------------------------------------
	assign sec_tick = (prescale == 32'(SEC_CYCLES - 1));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prescale <= 32'h0;
		end else if (sec_tick) begin
			prescale <= 32'h0;
		end else begin
			prescale <= prescale + 32'h1;
		end
	end

	// ----------------------------------------
	// Calendar increment
	// ----------------------------------------
	always_comb begin
		next_run = run;
		if (run.sec >= `RTCC_SEC_MAX) begin
			next_run.sec = 6'h0;
			if (run.min >= `RTCC_SEC_MAX) begin
				next_run.min = 6'h0;
				if (run.hour >= `RTCC_HOUR_MAX) begin
					next_run.hour = 5'h0;
					if (run.day >= month_days(run.mon, run.year)) begin
						next_run.day = `RTCC_DAY_MIN;
						if (run.mon >= `RTCC_MON_MAX) begin
							next_run.mon = `RTCC_MON_MIN;
							next_run.year = run.year + 6'h1;
						end else begin
							next_run.mon = run.mon + 4'h1;
						end
					end else begin
						next_run.day = run.day + 5'h1;
					end
				end else begin
					next_run.hour = run.hour + 5'h1;
				end
			end else begin
				next_run.min = run.min + 6'h1;
			end
		end else begin
			next_run.sec = run.sec + 6'h1;
		end
	end

	// ----------------------------------------
	// Running calendar
	// ----------------------------------------
	// A load that lands on a tick edge wins; that second is not counted
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			run <= '{sec: 6'h0, min: 6'h0, hour: 5'h0, day: `RTCC_DAY_MIN,
				mon: `RTCC_MON_MIN, year: 6'h0};
		end else if (wr && idx == `RTCC_IDX_CAL_YEAR) begin
			run <= '{sec: stage.sec, min: stage.min, hour: stage.hour, day: stage.day,
				mon: stage.mon, year: wbyte[5:0]};
		end else if (sec_tick) begin
			run <= next_run;
		end
	end

	// ----------------------------------------
	// Staged calendar registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage <= '{sec: 6'h0, min: 6'h0, hour: 5'h0, day: `RTCC_DAY_MIN,
				mon: `RTCC_MON_MIN, year: 6'h0};
		end else if (!read_done || (rd_acc && idx == `RTCC_IDX_CAL_SEC)) begin
			stage <= run;
		end else if (wr) begin
			unique case (idx)
				`RTCC_IDX_CAL_SEC: stage.sec <= wbyte[5:0];
				`RTCC_IDX_CAL_MIN: stage.min <= wbyte[5:0];
				`RTCC_IDX_CAL_HOUR: stage.hour <= wbyte[4:0];
				`RTCC_IDX_CAL_DAY: stage.day <= wbyte[4:0];
				`RTCC_IDX_CAL_MON: stage.mon <= wbyte[3:0];
				`RTCC_IDX_CAL_YEAR: stage.year <= wbyte[5:0];
				default: stage <= stage;
			endcase
		end
	end

	// Set the cycle after reset, when the first automatic snapshot lands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			read_done <= 1'b0;
		end else begin
			read_done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Power monitor
	// ----------------------------------------
	// Reset stands for loss of supply, so the monitor starts unarmed
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			power_ok <= 1'b0;
		end else if (wr && idx == `RTCC_IDX_CAL_YEAR && wbyte[`RTCC_BIT_MONITOR]) begin
			power_ok <= 1'b1;
		end
	end

	// ----------------------------------------
	// Seconds counter
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			epoch_run <= 32'h0;
		end else if (sec_tick) begin
			epoch_run <= epoch_run + 32'h1;
		end
	end

	// Held until the next low byte read, so well past half a second
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			epoch_snap <= 32'h0;
		end else if (rd_acc && idx == `RTCC_IDX_EPOCH0) begin
			epoch_snap <= epoch_run;
		end
	end

	// ----------------------------------------
	// Alarm settings
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wake_sec <= 6'h0;
		end else if (wr && idx == `RTCC_IDX_WAKE_SEC) begin
			wake_sec <= wbyte[5:0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wake_stage <= '{day: `RTCC_DAY_MIN, mon: `RTCC_MON_MIN, default: '0};
		end else if (wr) begin
			unique case (idx)
				`RTCC_IDX_WAKE_MIN: wake_stage.min <= wbyte[5:0];
				`RTCC_IDX_WAKE_HOUR: wake_stage.hour <= wbyte[4:0];
				`RTCC_IDX_WAKE_DAY: wake_stage.day <= wbyte[4:0];
				`RTCC_IDX_WAKE_MON: begin
					wake_stage.mon <= wbyte[3:0];
					wake_stage.tick_wake <= wbyte[`RTCC_BIT_TICK_WAKE];
					wake_stage.tick_type <= wbyte[`RTCC_BIT_TICK_TYPE];
				end
				`RTCC_IDX_WAKE_YEAR: begin
					wake_stage.year <= wbyte[5:0];
					wake_stage.tick_on <= wbyte[`RTCC_BIT_TICK_ON];
					wake_stage.alarm_on <= wbyte[`RTCC_BIT_ALARM_ON];
				end
				default: wake_stage <= wake_stage;
			endcase
		end
	end

	// Compare settings except wake_sec change only as a set on the year write; wake_sec takes effect as soon as it is written
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wake_act <= '{day: `RTCC_DAY_MIN, mon: `RTCC_MON_MIN, default: '0};
		end else if (wr && idx == `RTCC_IDX_WAKE_YEAR) begin
			wake_act <= '{min: wake_stage.min, hour: wake_stage.hour, day: wake_stage.day,
				mon: wake_stage.mon, tick_wake: wake_stage.tick_wake,
				tick_type: wake_stage.tick_type, year: wbyte[5:0],
				tick_on: wbyte[`RTCC_BIT_TICK_ON],
				alarm_on: wbyte[`RTCC_BIT_ALARM_ON]};
		end
	end

	// ----------------------------------------
	// Alarm events
	// ----------------------------------------
	assign match = wake_act.alarm_on && run.sec == wake_sec && run.min == wake_act.min
		&& run.hour == wake_act.hour && run.day == wake_act.day
		&& run.mon == wake_act.mon && run.year == wake_act.year;
	assign alarm_evt = match & ~match_q;
	assign tick_evt = sec_tick & wake_act.tick_on
		& (~wake_act.tick_type | (next_run.sec == 6'h0));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// A new event in the clearing cycle survives the read
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cause <= `RTCC_CAUSE_NONE;
		end else if (rd_acc && idx == `RTCC_IDX_WAKE_SEC) begin
			cause <= {alarm_evt, tick_evt};
		end else begin
			cause <= cause | {alarm_evt, tick_evt};
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wake_out <= 1'b0;
		end else begin
			wake_out <= alarm_evt | (tick_evt & wake_act.tick_wake);
		end
	end

endmodule : rtcc_top
`default_nettype wire

// *** rtcc_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_params.svh"
// ----
// Bus timing, error response, wake pulse and read-format checks
// ----
module rtcc_top_props #(
	parameter int unsigned SEC_CYCLES = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RTCC_ADDR_W-1:0] paddr,
	input wire rtcc_pkg::rtcc_word_t pwdata,
	input wire rtcc_pkg::rtcc_word_t prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wake_out
);
	import rtcc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic bad;
	logic rd_ok;
	logic [7:0] idx;
	assign idx = paddr[9:2];
	assign bad = paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0 || idx < 8'h40 || idx > 8'h4f;
	assign rd_ok = pready && psel && penable && !pwrite && !bad;
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	property p_wait;
		s_access |=> s_answer;
	endproperty
	property p_err;
		pready && psel && penable && bad |-> pslverr && (pwrite || prdata == '0);
	endproperty
	property p_err_only;
		pslverr |-> pready && bad;
	endproperty
	property p_wake;
		wake_out |=> !wake_out;
	endproperty
	property p_sec;
		rd_ok && idx == `RTCC_IDX_CAL_SEC |-> prdata[31:6] == 26'h2 && prdata[5:0] <= 6'h3b;
	endproperty
	property p_hour;
		rd_ok && idx == `RTCC_IDX_CAL_HOUR |-> prdata[31:5] == '0 && prdata[4:0] <= 5'h17;
	endproperty
	property p_day;
		rd_ok && idx == `RTCC_IDX_CAL_DAY |-> prdata[31:5] == '0 && prdata[4:0] >= 5'h01;
	endproperty
	property p_mon;
		rd_ok && idx == `RTCC_IDX_CAL_MON |-> prdata[31:4] == '0 && prdata[3:0] inside {[1:12]};
	endproperty
	property p_year;
		rd_ok && idx == `RTCC_IDX_CAL_YEAR |-> prdata[31:7] == '0;
	endproperty
	a_wait: assert property (p_wait) else $error("answer timing wrong");
	a_err: assert property (p_err) else $error("unmapped access not refused");
	a_err_only: assert property (p_err_only) else $error("error on mapped access");
	a_wake: assert property (p_wake) else $error("wake pulse too long");
	a_sec: assert property (p_sec) else $error("seconds byte bad");
	a_hour: assert property (p_hour) else $error("hours byte bad");
	a_day: assert property (p_day) else $error("day byte bad");
	a_mon: assert property (p_mon) else $error("month byte bad");
	a_year: assert property (p_year) else $error("year byte bad");
endmodule : rtcc_top_props
bind rtcc_top rtcc_top_props #(.SEC_CYCLES(SEC_CYCLES)) rtcc_top_props_i (.clock(clock),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_out(wake_out));
`default_nettype wire

// *** rtcc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module rtcc_top_tb;
	import rtcc_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rtcc_note_t;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [`RTCC_ADDR_W-1:0] paddr = '0;
	rtcc_word_t pwdata = '0, prdata;
	logic pready, pslverr, wake_out;
	int fail_count = 0, check_count = 0, wake_cnt = 0;
	rtcc_note_t notes[$];
	rtcc_note_t n;
	// Short second keeps the run small
	rtcc_top #(.SEC_CYCLES(40)) rtcc_top_i (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_out(wake_out));
	always #5 clock = ~clock;
	// Counted mid-cycle so that a pulse never races the edge at which a window opens or closes
	always @(negedge clock) if (wake_out === 1'b1) wake_cnt++;
	// ----
	// Monitor: oldest note against each answer
	// ----
	always @(posedge clock) if (psel && penable && pready === 1'b1) begin
		n = notes.pop_front();
		`CHK(pslverr, n.e)
		`CHK(prdata & n.m, n.d)
	end
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
		input logic [31:0] ed, input logic [31:0] em, input logic e);
		int k;
		notes.push_back('{d: ed & em, m: em, e: e});
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge clock);
		penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		psel <= 0;
		penable <= 0;
		if (k == 20) begin
			fail_count++;
			tally_and_finish();
		end
	endtask : apb
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1, {2'h0, i, 2'h0}, d, 0, 0, 0);
	endtask : wr
	task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic [31:0] m = '1);
		apb(0, {2'h0, i, 2'h0}, 0, d, m, 0);
	endtask : rd
	// Staged fields only reach the counters on the year write
	task automatic set_cal(input logic [7:0] v[6]);
		for (int k = 0; k < 6; k++) wr(`RTCC_IDX_CAL_SEC + 8'(k), v[k]);
	endtask : set_cal
	// One or two ticks land before the snapshot; both leave the same carry
	task automatic roll(input logic [7:0] mo, d, y, emo, ed, ey);
		logic [7:0] e[6];
		e = '{8'h0, 8'h0, 8'h0, ed, emo, ey | 8'h40};
		set_cal('{8'h3b, 8'h3b, 8'h17, d, mo, y | 8'h40});
		repeat (60) @(posedge clock);
		rd(`RTCC_IDX_CAL_SEC, 32'h80, 32'hfe);
		for (int k = 1; k < 6; k++) rd(`RTCC_IDX_CAL_SEC + 8'(k), e[k]);
	endtask : roll
	// ----
	// Main sequence
	// ----
	initial begin
		int unsigned r;
		int c0;
		logic [7:0] v[6];
		void'($urandom(32'hdc6e4e48));
		repeat (4) @(posedge clock);
		resetn <= 1;
		rd(`RTCC_IDX_CAL_SEC, 32'h80, 32'hc0);
		rd(`RTCC_IDX_CAL_YEAR, 0, 32'hffffffc0);
		rd(`RTCC_IDX_CAL_DAY, 1);
		rd(`RTCC_IDX_CAL_MON, 1);
		apb(0, 12'h200, 0, 0, '1, 1);
		apb(0, 12'h101, 0, 0, '1, 1);
		apb(1, 12'h0fc, 8'h5a, 0, 0, 1);
		rd(`RTCC_IDX_EPOCH0, 0, 0);
		wr(`RTCC_IDX_EPOCH3, 8'hff);
		rd(`RTCC_IDX_EPOCH3, 0);
		roll(2, 28, 4, 2, 29, 4);
		roll(2, 28, 5, 3, 1, 5);
		roll(4, 30, 5, 5, 1, 5);
		roll(12, 31, 3, 1, 1, 4);
		wr(`RTCC_IDX_CAL_YEAR, 8'h05);
		rd(`RTCC_IDX_CAL_YEAR, 32'h45);
		r = $urandom;
		v = '{0, 8'(r % 60), 8'((r >> 8) % 24), 8'(1 + (r >> 13) % 31),
			8'(1 + (r >> 18) % 12), 8'((r >> 22) % 64)};
		for (int k = 1; k < 6; k++) wr(`RTCC_IDX_WAKE_SEC + 8'(k), v[k]);
		for (int k = 1; k < 6; k++) rd(`RTCC_IDX_WAKE_SEC + 8'(k), v[k]);
		v = '{8'h02, 8'h0, 8'h0, 8'h1, 8'h1, 8'h40};
		for (int k = 0; k < 6; k++) wr(`RTCC_IDX_WAKE_SEC + 8'(k), v[k]);
		set_cal('{8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h40});
		c0 = wake_cnt;
		repeat (150) @(posedge clock);
		`CHK(wake_cnt - c0, 1)
		rd(`RTCC_IDX_WAKE_SEC, 32'h82);
		rd(`RTCC_IDX_WAKE_SEC, 32'h02);
		wr(`RTCC_IDX_WAKE_MON, 8'h21);
		wr(`RTCC_IDX_WAKE_YEAR, 8'h80);
		c0 = wake_cnt;
		repeat (200) @(posedge clock);
		`CHK(wake_cnt - c0, 5)
		rd(`RTCC_IDX_WAKE_SEC, 32'h42);
		wr(`RTCC_IDX_WAKE_MON, 8'h31);
		wr(`RTCC_IDX_WAKE_YEAR, 8'h80);
		// Two seconds short of a minute boundary: exactly one per-minute tick in the window
		set_cal('{8'h3a, 8'h0, 8'h0, 8'h1, 8'h1, 8'h40});
		c0 = wake_cnt;
		repeat (200) @(posedge clock);
		`CHK(wake_cnt - c0, 1)
		wr(`RTCC_IDX_WAKE_MON, 8'h01);
		wr(`RTCC_IDX_WAKE_YEAR, 8'h80);
		c0 = wake_cnt;
		repeat (200) @(posedge clock);
		`CHK(wake_cnt - c0, 0)
		tally_and_finish();
	end
endmodule : rtcc_top_tb
`default_nettype wire
